/* core/dcit_debounce.v */
// Per-input synchroniser and debounce filter for ground/open discretes.
`timescale 1ns/100ps

module dcit_debounce
#(
   parameter WIDTH  = 6,
   parameter CYCLES = 250000
)
(
   // Clock and reset
   input  wire             clk,
   input  wire             rst_n,
   // Raw discretes, low when grounded
   input  wire [WIDTH-1:0] raw_n,
   // Filtered levels, high when grounded
   output wire [WIDTH-1:0] level
);

   localparam CW = $clog2(CYCLES + 1);
   localparam integer  LAST_I = CYCLES - 1;
   localparam [CW-1:0] LAST = LAST_I[CW-1:0];

   genvar i;

   ////////////////////////////////////////////////////////////////////////
   generate
      for (i = 0; i < WIDTH; i = i + 1)
      begin : g_bit
         reg          meta_q;
         reg          sync_q;
         reg          lvl_q;
         reg [CW-1:0] cnt_q;

         // An open pin reads high, so reset assumes every input open.
         always @(posedge clk or negedge rst_n)
         begin
            if (!rst_n)
            begin
               meta_q <= 1'b1;
               sync_q <= 1'b1;
               lvl_q  <= 1'b0;
               cnt_q  <= {CW{1'b0}};
            end
            else
            begin
               meta_q <= raw_n[i];
               sync_q <= meta_q;
               if ((~sync_q) == lvl_q)
                  cnt_q <= {CW{1'b0}};
               else if (cnt_q == LAST)
               begin
                  lvl_q <= ~sync_q;
                  cnt_q <= {CW{1'b0}};
               end
               else
                  cnt_q <= cnt_q + 1'b1;
            end
         end

         assign level[i] = lvl_q;
      end
   endgenerate

endmodule

/* core/dcit_defs.vh */
// Constants for the discrete configuration and ident timer block.
`ifndef DCIT_DEFS_VH
`define DCIT_DEFS_VH

////////////////////////////////////////////////////////////////////////////
`define DCIT_CLK_HZ            25000000
`define DCIT_IDENT_TIME_MS     18000
`define DCIT_DEBOUNCE_TIME_MS  10

////////////////////////////////////////////////////////////////////////////
`define DCIT_ADDR_W            4
`define DCIT_DATA_W            32
`define DCIT_ADDR_STATUS       4'h0
`define DCIT_ADDR_CONFIG       4'h1
`define DCIT_ADDR_CTRL         4'h2
`define DCIT_ADDR_TIMER        4'h3
`define DCIT_ADDR_COUNT        4'h4

////////////////////////////////////////////////////////////////////////////
`define DCIT_ST_IDENT_ACTIVE   0
`define DCIT_ST_LATCHED        1
`define DCIT_ST_CHANGED        2
`define DCIT_ST_IDENT_LEVEL    3
`define DCIT_CF_SEL_LSB        0
`define DCIT_CF_NAV_HIGH       2
`define DCIT_CF_AIR_HIGH       3
`define DCIT_CF_POS_HIGH       4
`define DCIT_CF_TC_LSB         8
`define DCIT_CT_START          0
`define DCIT_CT_CANCEL         1
`define DCIT_CT_CLR_CHANGED    2

////////////////////////////////////////////////////////////////////////////
`define DCIT_IN_IDENT          0
`define DCIT_IN_NAV            1
`define DCIT_IN_AIR            2
`define DCIT_IN_POS            3
`define DCIT_IN_CS0            4
`define DCIT_IN_CS1            5
`define DCIT_IN_NUM            6

////////////////////////////////////////////////////////////////////////////
`define DCIT_CFG_0             2'h0
`define DCIT_CFG_1             2'h1
`define DCIT_CFG_2             2'h2
`define DCIT_TC_CFG0           5'h01
`define DCIT_TC_CFG1           5'h02
`define DCIT_TC_CFG2           5'h03
`define DCIT_RST_WORD          32'h00000000

`endif

/* core/dcit_ident_timer.v */
// Retriggerable ident hold timer.
`timescale 1ns/100ps

module dcit_ident_timer
#(
   parameter CYCLES = 450000000
)
(
   // Clock and reset
   input  wire                         clk,
   input  wire                         rst_n,
   // Control pulses
   input  wire                         start,
   input  wire                         cancel,
   // State
   output reg                          active_q,
   output reg  [$clog2(CYCLES+1)-1:0]  remain_q
);

   localparam CW = $clog2(CYCLES + 1);
   localparam integer  LOAD_I = CYCLES - 1;
   localparam [CW-1:0] LOAD = LOAD_I[CW-1:0];

   ////////////////////////////////////////////////////////////////////////
   // Start beats cancel so that a press in the cancel cycle is not lost.
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         active_q <= 1'b0;
         remain_q <= {CW{1'b0}};
      end
      else if (start)
      begin
         active_q <= 1'b1;
         remain_q <= LOAD;
      end
      else if (cancel)
      begin
         active_q <= 1'b0;
         remain_q <= {CW{1'b0}};
      end
      else if (remain_q != {CW{1'b0}})
         remain_q <= remain_q - 1'b1;
      else
         active_q <= 1'b0;
   end

endmodule

/* core/dcit_top.v */
// Discrete configuration sampling and remote ident timer, top level.
//
// Function
// - A momentary ground on the ident discrete sets the ident flag for 18 s.
// - With the ident discrete open and no timer running the flag is clear.
// - A grounded nav rate select runs the nav receiver at high speed.
// - An open nav rate select runs the nav receiver at low speed.
// - Rate selects are sampled once after power-up and held until reset.
// - The air data receiver rate follows its select as sampled at power-up.
// - The position receiver rate follows its select as sampled at power-up.
// - The register 0,5 type code follows the decoded configuration.
// - A grounded second configuration select decodes as configuration 2.
// - Both selects open give configuration 0, only the first gives 1.
`timescale 1ns/100ps
`include "dcit_defs.vh"

module dcit_top
#(
   parameter IDENT_CYCLES =
      `DCIT_IDENT_TIME_MS * (`DCIT_CLK_HZ / 1000),
   parameter DEB_CYCLES =
      `DCIT_DEBOUNCE_TIME_MS * (`DCIT_CLK_HZ / 1000),
   parameter [4:0] TC_CFG0 = `DCIT_TC_CFG0,
   parameter [4:0] TC_CFG1 = `DCIT_TC_CFG1,
   parameter [4:0] TC_CFG2 = `DCIT_TC_CFG2
)
(
   // Clock and reset
   input  wire                    clk,
   input  wire                    nrst,
   // Discrete pins, low when grounded
   input  wire                    ident_n,
   input  wire                    nav_rate_select_n,
   input  wire                    air_data_rate_select_n,
   input  wire                    position_rate_select_n,
   input  wire                    config_select_bit0_n,
   input  wire                    config_select_bit1_n,
   // Register port
   input  wire [`DCIT_ADDR_W-1:0] reg_addr,
   input  wire [`DCIT_DATA_W-1:0] reg_wdata,
   input  wire                    reg_wr,
   input  wire                    reg_rd,
   output reg  [`DCIT_DATA_W-1:0] reg_rdata_q,
   // Reply formatter and receiver controls
   output wire                    ident_flag,
   output reg                     config_valid_q,
   output reg  [1:0]              config_sel_q,
   output reg  [4:0]              reply_message_field_tc_q,
   output reg                     nav_rate_high_q,
   output reg                     air_data_rate_high_q,
   output reg                     position_rate_high_q
);

   localparam TW = $clog2(IDENT_CYCLES + 1);
   localparam SETTLE = 2 * DEB_CYCLES + 4;
   localparam SW = $clog2(SETTLE + 1);
   localparam integer  SETTLE_LAST_I = SETTLE - 1;
   localparam [SW-1:0] SETTLE_LAST = SETTLE_LAST_I[SW-1:0];

   ////////////////////////////////////////////////////////////////////////
   // Reset release through two flops; assertion stays asynchronous.
   reg  rst_meta_q;
   reg  rst_n_q;

   always @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         rst_meta_q <= 1'b0;
         rst_n_q    <= 1'b0;
      end
      else
      begin
         rst_meta_q <= 1'b1;
         rst_n_q    <= rst_meta_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Discrete filtering.
   wire [`DCIT_IN_NUM-1:0] raw_n;
   wire [`DCIT_IN_NUM-1:0] lvl;

   assign raw_n[`DCIT_IN_IDENT] = ident_n;
   assign raw_n[`DCIT_IN_NAV]   = nav_rate_select_n;
   assign raw_n[`DCIT_IN_AIR]   = air_data_rate_select_n;
   assign raw_n[`DCIT_IN_POS]   = position_rate_select_n;
   assign raw_n[`DCIT_IN_CS0]   = config_select_bit0_n;
   assign raw_n[`DCIT_IN_CS1]   = config_select_bit1_n;

   dcit_debounce
   #(
      .WIDTH  (`DCIT_IN_NUM),
      .CYCLES (DEB_CYCLES)
   )
   u_debounce
   (
      .clk    (clk),
      .rst_n  (rst_n_q),
      .raw_n  (raw_n),
      .level  (lvl)
   );

   ////////////////////////////////////////////////////////////////////////
   // Configuration decode from filtered selects.
   reg  [1:0] cfg_d;
   reg  [4:0] tc_d;

   always @*
   begin
      if (lvl[`DCIT_IN_CS1])
         cfg_d = `DCIT_CFG_2;
      else if (lvl[`DCIT_IN_CS0])
         cfg_d = `DCIT_CFG_1;
      else
         cfg_d = `DCIT_CFG_0;
      case (cfg_d)
         `DCIT_CFG_0: tc_d = TC_CFG0;
         `DCIT_CFG_1: tc_d = TC_CFG1;
         `DCIT_CFG_2: tc_d = TC_CFG2;
         default:     tc_d = TC_CFG0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Power-up sampling. The wait covers the filter's full settling time,
   // so straps that are wired before power-up are seen at their true level.
   // Later pin changes never reach the outputs; only a new reset does.
   reg  [SW-1:0] settle_q;
   reg           latch_now;

   always @*
   begin
      latch_now = (!config_valid_q) && (settle_q == SETTLE_LAST);
   end

   always @(posedge clk or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         settle_q                 <= {SW{1'b0}};
         config_valid_q           <= 1'b0;
         config_sel_q             <= `DCIT_CFG_0;
         reply_message_field_tc_q <= TC_CFG0;
         nav_rate_high_q          <= 1'b0;
         air_data_rate_high_q     <= 1'b0;
         position_rate_high_q     <= 1'b0;
      end
      else if (latch_now)
      begin
         config_valid_q           <= 1'b1;
         config_sel_q             <= cfg_d;
         reply_message_field_tc_q <= tc_d;
         nav_rate_high_q          <= lvl[`DCIT_IN_NAV];
         air_data_rate_high_q     <= lvl[`DCIT_IN_AIR];
         position_rate_high_q     <= lvl[`DCIT_IN_POS];
      end
      else if (!config_valid_q)
         settle_q <= settle_q + 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////
   // Ident press detection on the grounding edge.
   reg  ident_prev_q;
   reg  hw_start;
   wire sw_start;
   wire sw_cancel;
   wire timer_active;
   wire [TW-1:0] timer_remain;

   always @(posedge clk or negedge rst_n_q)
   begin
      if (!rst_n_q)
         ident_prev_q <= 1'b0;
      else
         ident_prev_q <= lvl[`DCIT_IN_IDENT];
   end

   always @*
   begin
      hw_start = lvl[`DCIT_IN_IDENT] && !ident_prev_q;
   end

   assign sw_start  = reg_wr && (reg_addr == `DCIT_ADDR_CTRL) &&
                      reg_wdata[`DCIT_CT_START];
   assign sw_cancel = reg_wr && (reg_addr == `DCIT_ADDR_CTRL) &&
                      reg_wdata[`DCIT_CT_CANCEL];

   dcit_ident_timer
   #(
      .CYCLES   (IDENT_CYCLES)
   )
   u_ident_timer
   (
      .clk      (clk),
      .rst_n    (rst_n_q),
      .start    (hw_start | sw_start),
      .cancel   (sw_cancel),
      .active_q (timer_active),
      .remain_q (timer_remain)
   );

   // The flag is the timer's own flop, so it needs no extra stage.
   assign ident_flag = timer_active;

   ////////////////////////////////////////////////////////////////////////
   // Sticky warning: a select moved after sampling and needs a power cycle.
   reg  changed_q;
   reg  [15:0] press_cnt_q;
   wire moved;
   wire clr_changed;

   assign moved = config_valid_q &&
                  ((lvl[`DCIT_IN_NAV] != nav_rate_high_q) ||
                   (lvl[`DCIT_IN_AIR] != air_data_rate_high_q) ||
                   (lvl[`DCIT_IN_POS] != position_rate_high_q) ||
                   (cfg_d != config_sel_q));
   assign clr_changed = reg_wr && (reg_addr == `DCIT_ADDR_CTRL) &&
                        reg_wdata[`DCIT_CT_CLR_CHANGED];

   always @(posedge clk or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         changed_q   <= 1'b0;
         press_cnt_q <= 16'h0000;
      end
      else
      begin
         if (moved)
            changed_q <= 1'b1;
         else if (clr_changed)
            changed_q <= 1'b0;
         if (hw_start)
            press_cnt_q <= press_cnt_q + 16'h0001;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Register read; data stand for the single cycle after the strobe.
   reg  [`DCIT_DATA_W-1:0] rd_d;

   always @*
   begin
      rd_d = `DCIT_RST_WORD;
      case (reg_addr)
         `DCIT_ADDR_STATUS:
         begin
            rd_d[`DCIT_ST_IDENT_ACTIVE] = timer_active;
            rd_d[`DCIT_ST_LATCHED]      = config_valid_q;
            rd_d[`DCIT_ST_CHANGED]      = changed_q;
            rd_d[`DCIT_ST_IDENT_LEVEL]  = lvl[`DCIT_IN_IDENT];
         end
         `DCIT_ADDR_CONFIG:
         begin
            rd_d[`DCIT_CF_SEL_LSB+1:`DCIT_CF_SEL_LSB] = config_sel_q;
            rd_d[`DCIT_CF_NAV_HIGH] = nav_rate_high_q;
            rd_d[`DCIT_CF_AIR_HIGH] = air_data_rate_high_q;
            rd_d[`DCIT_CF_POS_HIGH] = position_rate_high_q;
            rd_d[`DCIT_CF_TC_LSB+4:`DCIT_CF_TC_LSB] =
               reply_message_field_tc_q;
         end
         `DCIT_ADDR_TIMER:
            rd_d[TW-1:0] = timer_remain;
         `DCIT_ADDR_COUNT:
            rd_d[15:0] = press_cnt_q;
         default:
            rd_d = `DCIT_RST_WORD;
      endcase
   end

   always @(posedge clk or negedge rst_n_q)
   begin
      if (!rst_n_q)
         reg_rdata_q <= `DCIT_RST_WORD;
      else if (reg_rd)
         reg_rdata_q <= rd_d;
      else
         reg_rdata_q <= `DCIT_RST_WORD;
   end

endmodule

/* tb/dcit_straps.sv */
// Cockpit strap and momentary ident switch model for the discrete pins.
`timescale 1ns/100ps

module dcit_straps
(
   // Clock and strap requests, a set bit means grounded
   input wire       clk,
   input wire [4:0] strap,
   // Discrete pins, pulled up when open
   output reg       ident_n,
   output wire      nav_rate_select_n,
   output wire      air_data_rate_select_n,
   output wire      position_rate_select_n,
   output wire      config_select_bit0_n,
   output wire      config_select_bit1_n
);
   // An open strap floats to the pull-up, so open always reads high.
   assign {config_select_bit1_n, config_select_bit0_n, position_rate_select_n,
           air_data_rate_select_n, nav_rate_select_n} = ~strap;

   initial ident_n = 1'b1;

   // Contact bounce is a run of one-cycle toggles before the firm ground.
   task automatic press(input integer bounce, input integer hold);
      integer i;
      begin
         for (i = 0; i < bounce + hold; i = i + 1)
         begin
            @(posedge clk);
            ident_n <= i < bounce ? ~ident_n : 1'b0;
         end
         @(posedge clk);
         ident_n <= 1'b1;
      end
   endtask
endmodule

/* tb/dcit_top_properties.sv */
// Port-level assertions for the discrete configuration and ident block.
`timescale 1ns/100ps
`include "dcit_defs.vh"

module dcit_top_properties
#(
   parameter       IDENT_CYCLES = 50,
   parameter       DEB_CYCLES   = 4,
   parameter [4:0] TC_CFG0      = 5'h01,
   parameter [4:0] TC_CFG1      = 5'h02,
   parameter [4:0] TC_CFG2      = 5'h03
)
(
   // Clock, reset and pins
   input wire        clk,
   input wire        nrst,
   input wire        ident_n,
   input wire        nav_rate_select_n,
   input wire        air_data_rate_select_n,
   input wire        position_rate_select_n,
   input wire        config_select_bit0_n,
   input wire        config_select_bit1_n,
   // Register port
   input wire [3:0]  reg_addr,
   input wire [31:0] reg_wdata,
   input wire        reg_wr,
   input wire        reg_rd,
   input wire [31:0] reg_rdata_q,
   // Controls
   input wire        ident_flag,
   input wire        config_valid_q,
   input wire [1:0]  config_sel_q,
   input wire [4:0]  reply_message_field_tc_q,
   input wire        nav_rate_high_q,
   input wire        air_data_rate_high_q,
   input wire        position_rate_high_q
);
   localparam integer SETTLE = 2 * DEB_CYCLES + 4;
   wire       ctl_w    = reg_wr && reg_addr == `DCIT_ADDR_CTRL;
   wire       start_w  = ctl_w && reg_wdata[0];
   wire       cancel_w = ctl_w && reg_wdata[1] && !reg_wdata[0];
   wire [2:0] rates    = {nav_rate_high_q, air_data_rate_high_q,
                          position_rate_high_q};
   wire [1:0] sel_w    = !config_select_bit1_n ? 2'h2 :
                         {1'b0, !config_select_bit0_n};
   integer    hi_cnt;
   integer    open_cnt;
   integer    up_cnt;

   // The open and up counters saturate so that a long idle run cannot wrap and misfire.
   always @(posedge clk or negedge nrst)
      if (!nrst)
      begin
         hi_cnt <= 0;
         open_cnt <= 0;
         up_cnt <= 0;
      end
      else
      begin
         hi_cnt <= ident_flag ? hi_cnt + 1 : 0;
         open_cnt <= !ident_n ? 0 : open_cnt + (open_cnt < 255);
         up_cnt <= up_cnt + (up_cnt < 255);
      end

   // A fresh grounding edge, so a switch held past the timeout is no fault.
   sequence s_held;
      ident_n ##1 !ident_n [*8];
   endsequence
   sequence s_start;
      start_w;
   endsequence

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);

   chk_press_ident: assert property (s_held |-> ##[0:4] ident_flag)
      else $error("press did not raise ident");
   chk_start_ident: assert property (s_start |=> ident_flag)
      else $error("start did not raise ident");
   chk_ident_len: assert property (
      $fell(ident_flag) && !$past(cancel_w) |-> hi_cnt == IDENT_CYCLES)
      else $error("ident hold length wrong");
   chk_idle_clear: assert property (open_cnt > DEB_CYCLES + 4
      && !ident_flag && !start_w |=> !ident_flag)
      else $error("ident raised while open");
   chk_cfg_sample: assert property (
      $rose(config_valid_q) |->
      rates == {!nav_rate_select_n, !air_data_rate_select_n,
      !position_rate_select_n} && config_sel_q == sel_w)
      else $error("sampled configuration wrong");
   chk_cfg_hold: assert property (config_valid_q |=> config_valid_q
      && $stable({config_sel_q, reply_message_field_tc_q, rates}))
      else $error("configuration changed after sample");
   chk_sample_time: assert property ($rose(config_valid_q) |->
      up_cnt >= SETTLE && up_cnt <= SETTLE + 4)
      else $error("sample taken at wrong time");
   chk_sample_due: assert property (
      up_cnt == SETTLE + 5 |-> config_valid_q)
      else $error("sample not taken");
   chk_tc_map: assert property (
      config_sel_q != 2'h3 &&
      reply_message_field_tc_q == (config_sel_q == 2'h2 ? TC_CFG2 :
      config_sel_q == 2'h1 ? TC_CFG1 : TC_CFG0))
      else $error("type code does not follow configuration");
   chk_rd_idle: assert property (
      !$past(reg_rd) |-> reg_rdata_q == 32'h0)
      else $error("read data outside read cycle");
endmodule

/* tb/dcit_top_tb.sv */
// Self-checking bench for the discrete configuration and ident block.
`timescale 1ns/100ps
`include "dcit_defs.vh"

module dcit_top_tb;
   localparam integer IDC  = 50;
   localparam integer DEB  = 4;
   localparam [29:0]  PATS = {5'h00, 5'h04, 5'h1f, 5'h12, 5'h09, 5'h00};
   reg          clk = 1'b0;
   reg          nrst = 1'b0;
   reg  [4:0]   strap = 5'h00;
   reg  [3:0]   reg_addr = 4'h0;
   reg  [31:0]  reg_wdata = 32'h0;
   reg          reg_wr = 1'b0;
   reg          reg_rd = 1'b0;
   reg          rd_pend = 1'b0;
   reg          cv_prev = 1'b0;
   reg  [4:0]   s;
   reg  [9:0]   e;
   reg  [31:0]  w;
   wire         ident_n, nav_rate_select_n, air_data_rate_select_n;
   wire         position_rate_select_n, config_select_bit0_n;
   wire         config_select_bit1_n, ident_flag, config_valid_q;
   wire         nav_rate_high_q, air_data_rate_high_q, position_rate_high_q;
   wire [1:0]   config_sel_q;
   wire [4:0]   reply_message_field_tc_q;
   wire [31:0]  reg_rdata_q;
   integer      n_errors = 0;
   integer      compares = 0;
   integer      hi_len = 0;
   integer      i;
   integer      seed;
   logic [31:0] q_rd[$];
   logic [9:0]  q_cfg[$];
   logic [31:0] q_len[$];

   always #20 clk = ~clk;

   dcit_straps u_sw (.clk, .strap, .ident_n, .nav_rate_select_n,
      .air_data_rate_select_n, .position_rate_select_n,
      .config_select_bit0_n, .config_select_bit1_n);
   dcit_top #(.IDENT_CYCLES(IDC), .DEB_CYCLES(DEB)) dut (.clk, .nrst,
      .ident_n, .nav_rate_select_n, .air_data_rate_select_n,
      .position_rate_select_n, .config_select_bit0_n, .config_select_bit1_n,
      .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_q, .ident_flag,
      .config_valid_q, .config_sel_q, .reply_message_field_tc_q,
      .nav_rate_high_q, .air_data_rate_high_q, .position_rate_high_q);

   ////////////////////////////////////////////////////////////////////////////
   task automatic cyc(input integer n);
      repeat (n) @(posedge clk);
   endtask
   task automatic wr(input [3:0] a, input [31:0] d);
      begin
         @(posedge clk);
         reg_wr <= 1'b1;
         reg_addr <= a;
         reg_wdata <= d;
         @(posedge clk);
         reg_wr <= 1'b0;
      end
   endtask
   task automatic rd(input [3:0] a, input [31:0] x);
      begin
         @(posedge clk);
         reg_rd <= 1'b1;
         reg_addr <= a;
         q_rd.push_back(x);
         @(posedge clk);
         reg_rd <= 1'b0;
      end
   endtask
   task automatic chk(input string n, input [31:0] x, input [31:0] g);
      begin
         compares = compares + 1;
         if (g !== x)
         begin
            n_errors = n_errors + 1;
            $display("BAD %s expected %h seen %h", n, x, g);
         end
      end
   endtask
   task automatic cmp_rd(input [31:0] x, input [31:0] g);
      chk("rdata", x, g);
   endtask
   task automatic cmp_cfg(input [9:0] x, input [9:0] g);
      chk("config", {22'h0, x}, {22'h0, g});
   endtask
   task automatic cmp_len(input [31:0] x, input [31:0] g);
      chk("ident_len", x, g);
   endtask
   task end_sim;
      begin
         if (q_rd.size() + q_cfg.size() + q_len.size() != 0)
         begin
            n_errors = n_errors + 1;
            $display("BAD queues expected 0 seen %0d",
                     q_rd.size() + q_cfg.size() + q_len.size());
         end
         if (n_errors == 0 && compares > 0)
            $display("Run complete: PASS");
         else
            $display("Run complete: FAIL");
         $finish;
      end
   endtask
   function automatic [9:0] exp_cfg(input [4:0] v);
      reg [1:0] sl;
      begin
         sl = v[4] ? 2'h2 : {1'b0, v[3]};
         exp_cfg = {sl, (sl == 2'h2 ? `DCIT_TC_CFG2 : sl[0] ? `DCIT_TC_CFG1
                   : `DCIT_TC_CFG0), v[0], v[1], v[2]};
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Outputs are read before the edge's own updates land, so no races.
   always @(posedge clk)
   begin
      if (rd_pend)
         cmp_rd(q_rd.pop_front(), reg_rdata_q);
      rd_pend = reg_rd;
      if (config_valid_q === 1'b1 && !cv_prev)
         cmp_cfg(q_cfg.pop_front(),
            {config_sel_q, reply_message_field_tc_q, nav_rate_high_q,
             air_data_rate_high_q, position_rate_high_q});
      cv_prev = config_valid_q;
      if (ident_flag === 1'b1)
         hi_len = hi_len + 1;
      else if (hi_len > 0)
      begin
         cmp_len(q_len.pop_front(), hi_len);
         hi_len = 0;
      end
   end

   initial
   begin
      #200000;
      n_errors = n_errors + 1;
      $display("BAD watchdog expected done seen timeout");
      end_sim;
   end

   initial
   begin
      seed = $urandom(74);
      for (i = 0; i < 6; i = i + 1)
      begin
         s = PATS[i*5 +: 5];
         if (i == 5)
            s = 5'($urandom);
         @(posedge clk);
         strap <= s;
         nrst <= 1'b0;
         cyc(5);
         nrst <= 1'b1;
         e = exp_cfg(s);
         w = {19'h0, e[7:3], 3'h0, e[0], e[1], e[2], e[9:8]};
         q_cfg.push_back(e);
         cyc(2 * DEB + 12);
         rd(`DCIT_ADDR_CONFIG, w);
         rd(`DCIT_ADDR_STATUS, 32'h2);
         rd(4'h9, 32'h0);
         rd(`DCIT_ADDR_CTRL, 32'h0);
      end
      // A strap moved after the sample must not reach the receivers.
      strap <= s ^ 5'h01;
      cyc(DEB + 6);
      rd(`DCIT_ADDR_CONFIG, w);
      rd(`DCIT_ADDR_STATUS, 32'h6);
      strap <= s;
      cyc(DEB + 6);
      wr(`DCIT_ADDR_CTRL, 32'h4);
      rd(`DCIT_ADDR_STATUS, 32'h2);
      u_sw.press(0, 2);
      cyc(20);
      rd(`DCIT_ADDR_STATUS, 32'h2);
      q_len.push_back(IDC);
      u_sw.press(4, 10);
      cyc(20);
      rd(`DCIT_ADDR_STATUS, 32'h3);
      rd(`DCIT_ADDR_COUNT, 32'h1);
      cyc(IDC);
      q_len.push_back(IDC);
      wr(`DCIT_ADDR_CTRL, 32'h1);
      // Loaded with IDC - 1 at the write, one count gone by the read.
      rd(`DCIT_ADDR_TIMER, IDC - 2);
      cyc(IDC + 3);
      q_len.push_back(10);
      wr(`DCIT_ADDR_CTRL, 32'h1);
      cyc(8);
      wr(`DCIT_ADDR_CTRL, 32'h2);
      cyc(5);
      q_len.push_back(IDC);
      wr(`DCIT_ADDR_CTRL, 32'h3);
      cyc(IDC + 5);
      rd(`DCIT_ADDR_COUNT, 32'h1);
      rd(`DCIT_ADDR_TIMER, 32'h0);
      cyc(3);
      end_sim;
   end
endmodule

bind dcit_top dcit_top_properties #(.IDENT_CYCLES(IDENT_CYCLES),
   .DEB_CYCLES(DEB_CYCLES), .TC_CFG0(TC_CFG0), .TC_CFG1(TC_CFG1),
   .TC_CFG2(TC_CFG2)) u_chk (.clk, .nrst, .ident_n, .nav_rate_select_n,
   .air_data_rate_select_n, .position_rate_select_n, .config_select_bit0_n,
   .config_select_bit1_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
   .reg_rdata_q, .ident_flag, .config_valid_q, .config_sel_q,
   .reply_message_field_tc_q, .nav_rate_high_q, .air_data_rate_high_q,
   .position_rate_high_q);
